// >>> core/lcdh_pkg.sv
// Constants and types shared by the display driver host sequencer
package lcdh_pkg;

  // Clock in MHz and wait times in microseconds
  localparam int CLK_MHZ                = 100;
  localparam int RESET_PULSE_US         = 1000;
  localparam int SERIAL_START_WAIT_US   = 1000;
  localparam int BOOSTER_SETTLE_WAIT_US = 200000;
  localparam int BIAS_SETTLE_WAIT_US    = 20000;
  localparam int STANDBY_STOP_WAIT_US   = 200000;

  // Cycle counts; times are whole microseconds so no rounding is lost
  localparam int RESET_PULSE_CYC         = RESET_PULSE_US * CLK_MHZ;
  localparam int SERIAL_START_WAIT_CYC   = SERIAL_START_WAIT_US * CLK_MHZ;
  localparam int BOOSTER_SETTLE_WAIT_CYC = BOOSTER_SETTLE_WAIT_US * CLK_MHZ;
  localparam int BIAS_SETTLE_WAIT_CYC    = BIAS_SETTLE_WAIT_US * CLK_MHZ;
  localparam int STANDBY_STOP_WAIT_CYC   = STANDBY_STOP_WAIT_US * CLK_MHZ;
  localparam int WAIT_W                  = 25;

  // External clock for the device pin, within 100 to 600 kHz
  localparam int EXT_CLK_KHZ      = 200;
  localparam int EXT_CLK_HALF_CYC = (CLK_MHZ * 1000) / (2 * EXT_CLK_KHZ);

  // Instruction word layout
  localparam int INSTR_W          = 32;
  localparam int METHOD_CLKSEL    = 0;
  localparam int METHOD_BOOST     = 1;
  localparam int METHOD_CTC_LO    = 2;
  localparam int METHOD_CTC_HI    = 3;
  localparam int ONOFF_STATE_LO   = 0;
  localparam int ONOFF_STATE_HI   = 1;
  localparam int ONOFF_STANDBY    = 2;

  typedef enum logic [4:0] {
    ST_OFF       = 5'h00,
    ST_RST_HOLD  = 5'h01,
    ST_SER_WAIT  = 5'h02,
    ST_SND_METH  = 5'h03,
    ST_SND_CONT  = 5'h04,
    ST_SND_RAM   = 5'h05,
    ST_SND_LINE  = 5'h06,
    ST_SETTLE    = 5'h07,
    ST_SND_ON    = 5'h08,
    ST_RUN       = 5'h09,
    ST_SND_STBY  = 5'h0a,
    ST_STOP_WAIT = 5'h0b,
    ST_SND_SAVE  = 5'h0c,
    ST_SAVE      = 5'h0d,
    ST_SND_WAKE  = 5'h0e,
    ST_WAKE_WAIT = 5'h0f
  } lcdh_state_e;

endpackage

// >>> core/lcdh_clkdiv.sv
// Divider that makes the device's external fundamental clock
`timescale 1ns/1ps
module lcdh_clkdiv
  import lcdh_pkg::*;
#(
  parameter int HALF_CYC = EXT_CLK_HALF_CYC
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Control and output
  input  wire logic en_i,
  output logic      clk_o
);

  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic        lvl_q;
  logic        lvl_d;

  always_comb begin
    cnt_d = cnt_q;
    lvl_d = lvl_q;
    if (!en_i) begin
      cnt_d = 16'h0000;
      lvl_d = 1'b0;
    end else if (cnt_q == 16'(HALF_CYC - 1)) begin
      cnt_d = 16'h0000;
      lvl_d = ~lvl_q;
    end else begin
      cnt_d = cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 16'h0000;
      lvl_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      lvl_q <= lvl_d;
    end
  end

  assign clk_o = lvl_q;

endmodule // lcdh_clkdiv

// >>> core/lcdh_shifter.sv
// Link-clock serial shifter with toggle handshake toward the sequencer
`timescale 1ns/1ps
module lcdh_shifter
  import lcdh_pkg::*;
#(
  parameter int W = INSTR_W
) (
  // Link clock and reset
  input  wire logic         link_clk_i,
  input  wire logic         rst_i,
  // Handshake from the system clock domain
  input  wire logic         req_tgl_i,
  input  wire logic [W-1:0] word_i,
  output logic              ack_tgl_o,
  // Serial pins
  output logic              ser_en_o,
  output logic              ser_clk_o,
  output logic              ser_dat_o
);

  logic         s1_q, s2_q, s3_q;
  logic         busy_q, busy_d;
  logic         ph_q, ph_d;
  logic [5:0]   bit_q, bit_d;
  logic [W-1:0] sh_q, sh_d;
  logic         ack_q, ack_d;

  // Word is held stable by the sender until the ack returns, so it is
  // safe to sample here once the toggle has passed two flops
  always_comb begin
    busy_d = busy_q;
    ph_d   = ph_q;
    bit_d  = bit_q;
    sh_d   = sh_q;
    ack_d  = ack_q;
    if (!busy_q) begin
      if (s2_q ^ s3_q) begin
        busy_d = 1'b1;
        ph_d   = 1'b0;
        bit_d  = 6'h00;
        sh_d   = word_i;
      end
    end else if (!ph_q) begin
      ph_d = 1'b1;
    end else begin
      ph_d = 1'b0;
      sh_d = {sh_q[W-2:0], 1'b0};
      if (bit_q == 6'(W - 1)) begin
        busy_d = 1'b0;
        ack_d  = ~ack_q;
      end else begin
        bit_d = bit_q + 6'h01;
      end
    end
  end

  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      s3_q   <= 1'b0;
      busy_q <= 1'b0;
      ph_q   <= 1'b0;
      bit_q  <= 6'h00;
      sh_q   <= '0;
      ack_q  <= 1'b0;
    end else begin
      s1_q   <= req_tgl_i;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      busy_q <= busy_d;
      ph_q   <= ph_d;
      bit_q  <= bit_d;
      sh_q   <= sh_d;
      ack_q  <= ack_d;
    end
  end

  assign ser_en_o  = busy_q;
  assign ser_clk_o = busy_q & ph_q;
  assign ser_dat_o = busy_q & sh_q[W-1];
  assign ack_tgl_o = ack_q;

endmodule // lcdh_shifter

// >>> core/lcdh_seq.sv
// Host sequencer for reset, start-up, shut-down and power saving of the driver
`timescale 1ns/1ps
module lcdh_seq
  import lcdh_pkg::*;
#(
  parameter int RST_CYC    = RESET_PULSE_CYC,
  parameter int SER_CYC    = SERIAL_START_WAIT_CYC,
  parameter int BOOST_CYC  = BOOSTER_SETTLE_WAIT_CYC,
  parameter int BIAS_CYC   = BIAS_SETTLE_WAIT_CYC,
  parameter int STOP_CYC   = STANDBY_STOP_WAIT_CYC,
  parameter int CLK_HALF   = EXT_CLK_HALF_CYC
) (
  // Clocks and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               link_clk_i,
  // User commands (one-cycle pulses)
  input  wire logic               power_up_i,
  input  wire logic               power_down_i,
  input  wire logic               save_enter_i,
  input  wire logic               save_exit_i,
  // User configuration, taken with power_up_i
  input  wire logic               clock_source_select_i,
  input  wire logic               booster_enable_i,
  input  wire logic [1:0]         contrast_path_select_i,
  // Instruction words supplied by the user
  input  wire logic [INSTR_W-1:0] method_word_i,
  input  wire logic [INSTR_W-1:0] contrast_word_i,
  input  wire logic [INSTR_W-1:0] ram_word_i,
  input  wire logic [INSTR_W-1:0] line_word_i,
  input  wire logic [INSTR_W-1:0] onoff_word_i,
  // Status
  output logic                    busy_o,
  output logic                    display_on_o,
  output logic                    saving_o,
  output logic [4:0]              state_o,
  // Device pins
  output logic                    active_low_reset_pin_n_o,
  output logic                    clock_input_pin_o,
  output logic                    ser_en_o,
  output logic                    ser_clk_o,
  output logic                    ser_dat_o
);

  ////////////////////////////////////////////////////////////////////////////////

  lcdh_state_e        st_q, st_d;
  logic [WAIT_W-1:0]  cnt_q, cnt_d;
  logic               pend_q, pend_d;
  logic               req_q, req_d;
  logic [INSTR_W-1:0] word_q, word_d;
  logic               ext_q, ext_d;
  logic               boost_q, boost_d;
  logic [1:0]         ctc_q, ctc_d;
  logic               rstn_q, rstn_d;
  logic               ack_tgl;
  logic               a1_q, a2_q, a3_q;
  logic               done;

  // Display method word with the sequencer-owned bits forced in
  logic [INSTR_W-1:0] meth_w;
  always_comb begin
    meth_w                = method_word_i;
    meth_w[METHOD_CLKSEL] = ext_q;
    meth_w[METHOD_BOOST]  = boost_q;
    meth_w[METHOD_CTC_LO] = ctc_q[0];
    meth_w[METHOD_CTC_HI] = ctc_q[1];
  end

  function automatic logic [INSTR_W-1:0] onoff(input logic [INSTR_W-1:0] base,
                                                input logic sc, input logic sb);
    logic [INSTR_W-1:0] w;
    w                 = base;
    w[ONOFF_STATE_LO] = sc;
    w[ONOFF_STATE_HI] = sc;
    w[ONOFF_STANDBY]  = sb;
    return w;
  endfunction

  // One toggle per finished word, so no return-to-zero phase is needed
  assign done = a2_q ^ a3_q;

  ////////////////////////////////////////////////////////////////////////////////

  // Waits count down to zero, so a load of N-1 gives exactly N cycles
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    pend_d  = pend_q;
    req_d   = req_q;
    word_d  = word_q;
    ext_d   = ext_q;
    boost_d = boost_q;
    ctc_d   = ctc_q;
    rstn_d  = rstn_q;
    unique case (st_q)
      ST_OFF: begin
        rstn_d = 1'b0;
        // Settings are latched once per run so a later change cannot split it
        if (power_up_i) begin
          ext_d   = clock_source_select_i;
          boost_d = booster_enable_i;
          ctc_d   = contrast_path_select_i;
          cnt_d   = WAIT_W'(RST_CYC - 1);
          st_d    = ST_RST_HOLD;
        end
      end
      ST_RST_HOLD: begin
        if (cnt_q == '0) begin
          rstn_d = 1'b1;
          cnt_d  = WAIT_W'(SER_CYC - 1);
          st_d   = ST_SER_WAIT;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ST_SER_WAIT: begin
        // Nothing is shifted while reset is low or just after its release
        if (cnt_q == '0) begin
          st_d = ST_SND_METH;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ST_SND_METH, ST_SND_CONT, ST_SND_RAM, ST_SND_LINE,
      ST_SND_ON, ST_SND_STBY, ST_SND_SAVE, ST_SND_WAKE: begin
        // Raise the word once by toggling req, then hold it until the ack returns
        if (!pend_q) begin
          pend_d = 1'b1;
          req_d  = ~req_q;
          unique case (st_q)
            ST_SND_METH: word_d = meth_w;
            ST_SND_CONT: word_d = contrast_word_i;
            ST_SND_RAM:  word_d = ram_word_i;
            ST_SND_LINE: word_d = line_word_i;
            ST_SND_ON:   word_d = onoff(onoff_word_i, 1'b0, 1'b0);
            ST_SND_STBY: word_d = onoff(onoff_word_i, 1'b0, 1'b1);
            ST_SND_SAVE: word_d = onoff(onoff_word_i, 1'b1, 1'b1);
            default:     word_d = onoff(onoff_word_i, 1'b1, 1'b0);
          endcase
        end else if (done) begin
          pend_d = 1'b0;
          unique case (st_q)
            ST_SND_METH: st_d = ST_SND_CONT;
            ST_SND_CONT: st_d = ST_SND_RAM;
            ST_SND_RAM:  st_d = ST_SND_LINE;
            ST_SND_LINE: begin
              // Settle time depends on whether the internal booster must charge
              st_d  = ST_SETTLE;
              cnt_d = boost_q ? WAIT_W'(BOOST_CYC - 1)
                              : WAIT_W'(BIAS_CYC - 1);
            end
            ST_SND_ON:   st_d = ST_RUN;
            ST_SND_STBY: begin
              st_d  = ST_STOP_WAIT;
              cnt_d = WAIT_W'(STOP_CYC - 1);
            end
            ST_SND_SAVE: st_d = ST_SAVE;
            default: begin
              st_d  = ST_WAKE_WAIT;
              cnt_d = WAIT_W'(STOP_CYC - 1);
            end
          endcase
        end
      end
      ST_SETTLE, ST_WAKE_WAIT: begin
        if (cnt_q == '0) begin
          st_d = ST_SND_ON;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ST_RUN: begin
        // Power-down wins over save entry when both arrive together
        if (power_down_i) begin
          st_d = ST_SND_STBY;
        end else if (save_enter_i) begin
          st_d = ST_SND_SAVE;
        end
      end
      ST_SAVE: begin
        if (power_down_i) begin
          st_d = ST_SND_STBY;
        end else if (save_exit_i) begin
          st_d = ST_SND_WAKE;
        end
      end
      ST_STOP_WAIT: begin
        if (cnt_q == '0) begin
          rstn_d = 1'b0;
          // Clock pin stops with reset so the held device sees no clock
          ext_d  = 1'b0;
          st_d   = ST_OFF;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: begin
        st_d   = ST_OFF;
        rstn_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q    <= ST_OFF;
      cnt_q   <= '0;
      pend_q  <= 1'b0;
      req_q   <= 1'b0;
      word_q  <= '0;
      ext_q   <= 1'b0;
      boost_q <= 1'b0;
      ctc_q   <= 2'h0;
      rstn_q  <= 1'b0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      pend_q  <= pend_d;
      req_q   <= req_d;
      word_q  <= word_d;
      ext_q   <= ext_d;
      boost_q <= boost_d;
      ctc_q   <= ctc_d;
      rstn_q  <= rstn_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  // Ack toggle from the link domain; only the second and third flops feed logic
  logic a1_d, a2_d, a3_d;
  always_comb begin
    a1_d = ack_tgl;
    a2_d = a1_q;
    a3_d = a2_q;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      a1_q <= 1'b0;
      a2_q <= 1'b0;
      a3_q <= 1'b0;
    end else begin
      a1_q <= a1_d;
      a2_q <= a2_d;
      a3_q <= a3_d;
    end
  end

  // Status flags come from flops loaded from the next state, in step with state_o
  logic busy_q, busy_d;
  logic don_q, don_d;
  logic sav_q, sav_d;
  always_comb begin
    busy_d = (st_d != ST_OFF) && (st_d != ST_RUN) && (st_d != ST_SAVE);
    don_d  = (st_d == ST_RUN);
    sav_d  = (st_d == ST_SAVE);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      don_q  <= 1'b0;
      sav_q  <= 1'b0;
    end else begin
      busy_q <= busy_d;
      don_q  <= don_d;
      sav_q  <= sav_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  // Clock pin stays low unless external mode was chosen at power-up
  lcdh_clkdiv #(
    .HALF_CYC (CLK_HALF)
  ) u_clkdiv (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .en_i  (ext_q),
    .clk_o (clock_input_pin_o)
  );

  // Word crosses to the link domain; it is held until the ack toggle comes back
  lcdh_shifter #(
    .W (INSTR_W)
  ) u_shifter (
    .link_clk_i (link_clk_i),
    .rst_i      (rst_i),
    .req_tgl_i  (req_q),
    .word_i     (word_q),
    .ack_tgl_o  (ack_tgl),
    .ser_en_o   (ser_en_o),
    .ser_clk_o  (ser_clk_o),
    .ser_dat_o  (ser_dat_o)
  );

  assign active_low_reset_pin_n_o = rstn_q;
  assign busy_o       = busy_q;
  assign display_on_o = don_q;
  assign saving_o     = sav_q;
  assign state_o      = st_q;

endmodule // lcdh_seq

// >>> test/lcdh_seq_chk.sv
// Port-level assertions for the host sequencer
`timescale 1ns/1ps
module lcdh_seq_chk
  import lcdh_pkg::*;
#(
  parameter int RST_CYC  = 20,
  parameter int SER_CYC  = 20,
  parameter int BOOST_CYC = 200,
  parameter int BIAS_CYC = 50,
  parameter int STOP_CYC = 200
) (
  // Clock, reset and power-up settings
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       power_up_i,
  input wire logic       clock_source_select_i,
  input wire logic       booster_enable_i,
  // Status and device pins
  input wire logic       busy_o,
  input wire logic       saving_o,
  input wire logic [4:0] state_o,
  input wire logic       active_low_reset_pin_n_o,
  input wire logic       clock_input_pin_o,
  input wire logic       ser_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic        ext_q, ext_d, boost_q, boost_d;
  logic [31:0] up_q, up_d, hi_q, hi_d, set_q, set_d, idle_q, idle_d, need;
  logic        take;
  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    take    = power_up_i && state_o == ST_OFF;
    ext_d   = take ? clock_source_select_i : ext_q;
    boost_d = take ? booster_enable_i : boost_q;
    up_d    = take ? 32'h0 : up_q + 32'h1;
    hi_d    = active_low_reset_pin_n_o ? hi_q + 32'h1 : 32'h0;
    set_d   = (state_o == ST_SETTLE) ? set_q + 32'h1 : 32'h0;
    // Idle time since the last word left the link
    idle_d  = ser_en_o ? 32'h0 : idle_q + 32'h1;
    need    = boost_q ? BOOST_CYC : BIAS_CYC;
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {ext_q, boost_q} <= 2'h0;
      {up_q, hi_q, set_q, idle_q} <= '0;
    end else begin
      {ext_q, boost_q} <= {ext_d, boost_d};
      {up_q, hi_q, set_q, idle_q} <= {up_d, hi_d, set_d, idle_d};
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_settle_end;
    $past(state_o) == ST_SETTLE && state_o == ST_SND_ON;
  endsequence
  sequence s_wake_end;
    $past(state_o) == ST_WAKE_WAIT && state_o != ST_WAKE_WAIT;
  endsequence
  property p_clk_gnd; !ext_q |-> !clock_input_pin_o; endproperty
  a_clk_gnd: assert property (p_clk_gnd) else $error("clock pin active");
  // Bench sets the half period to 4 cycles; the half period cut at power-down is skipped
  property p_clk_ext;
    ext_q && $rose(clock_input_pin_o) && state_o != ST_STOP_WAIT && state_o != ST_OFF
      |-> clock_input_pin_o[*4] ##1 !clock_input_pin_o;
  endproperty
  a_clk_ext: assert property (p_clk_ext) else $error("clock pin period");
  property p_rst_pulse; $rose(active_low_reset_pin_n_o) |-> up_q >= RST_CYC; endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset too short");
  property p_ser_start; $rose(ser_en_o) |-> hi_q >= SER_CYC; endproperty
  a_ser_start: assert property (p_ser_start) else $error("serial too early");
  property p_no_ser_rst; !active_low_reset_pin_n_o |-> !ser_en_o; endproperty
  a_no_ser_rst: assert property (p_no_ser_rst) else $error("serial in reset");
  property p_settle; s_settle_end |-> set_q >= need && set_q <= need + 3; endproperty
  a_settle: assert property (p_settle) else $error("settle wait wrong");
  property p_stop; $fell(active_low_reset_pin_n_o) |-> idle_q >= STOP_CYC; endproperty
  a_stop: assert property (p_stop) else $error("stop wait short");
  property p_wake; s_wake_end |-> idle_q >= STOP_CYC; endproperty
  a_wake: assert property (p_wake) else $error("wake wait short");
  property p_save; $rose(saving_o) |-> $past(state_o) == ST_SND_SAVE && !busy_o; endproperty
  a_save: assert property (p_save) else $error("save entry wrong");
endmodule // lcdh_seq_chk

bind lcdh_seq lcdh_seq_chk #(.RST_CYC(RST_CYC), .SER_CYC(SER_CYC), .BOOST_CYC(BOOST_CYC),
  .BIAS_CYC(BIAS_CYC), .STOP_CYC(STOP_CYC)) lcdh_seq_chk_inst (.clk_i(clk_i), .rst_i(rst_i),
  .power_up_i(power_up_i), .clock_source_select_i(clock_source_select_i),
  .booster_enable_i(booster_enable_i), .busy_o(busy_o), .saving_o(saving_o),
  .state_o(state_o), .active_low_reset_pin_n_o(active_low_reset_pin_n_o),
  .clock_input_pin_o(clock_input_pin_o), .ser_en_o(ser_en_o));

// >>> test/lcdh_dev_model.sv
// Behavioural model of the display driver's reset and serial intake
`timescale 1ns/1ps
module lcdh_dev_model (
  // Device pins
  input  wire logic        active_low_reset_pin_n_i,
  input  wire logic        ser_en_i,
  input  wire logic        ser_clk_i,
  input  wire logic        ser_dat_i,
  // Observation
  output logic [31:0]      word_o,
  output int               word_cnt_o,
  output logic             drv_off_o
);
  logic [31:0] sh;
  int          nb;
  initial begin
    word_o     = 32'h0;
    word_cnt_o = 0;
  end
  // Outputs sit at the lowest bias level and analog blocks stop in reset
  assign drv_off_o = !active_low_reset_pin_n_i;
  // Stored word is kept across reset, like RAM and latch contents
  always @(posedge ser_clk_i or negedge ser_en_i or negedge active_low_reset_pin_n_i) begin
    if (!active_low_reset_pin_n_i) begin
      sh = 32'h0;
      nb = 0;
    end else if (!ser_en_i) begin
      if (nb == 32) begin
        word_o = sh;
        word_cnt_o++;
      end
      nb = 0;
    end else begin
      sh = {sh[30:0], ser_dat_i};
      nb++;
    end
  end
endmodule // lcdh_dev_model

// >>> test/tb_lcdh_seq.sv
// Self-checking bench for the display driver host sequencer
`timescale 1ns/1ps
module tb_lcdh_seq;
  import lcdh_pkg::*;
  logic               clk_i = 1'b0, link_clk_i = 1'b0, rst_i = 1'b1;
  logic [3:0]         cmd = 4'h0;
  logic               ext = 1'b0, boost = 1'b0;
  logic [1:0]         ctc = 2'h0;
  logic [INSTR_W-1:0] w [5] = '{default: '0};
  logic               busy, don, sav, rpin, cpin, sen, sclk, sdat;
  logic [4:0]         st;
  logic [31:0]        mword;
  int                 mcnt, got = 0, error_cnt = 0, comparisons = 0;
  logic               doff;
  // Shortened waits so a whole run stays short
  localparam int T_RST = 20, T_SER = 20, T_BOOST = 200;
  localparam int T_BIAS = 50, T_STOP = 200, T_HALF = 4;

  always #5 clk_i = ~clk_i;
  initial begin
    #3;
    forever #40 link_clk_i = ~link_clk_i;
  end

  lcdh_seq #(.RST_CYC(T_RST), .SER_CYC(T_SER), .BOOST_CYC(T_BOOST), .BIAS_CYC(T_BIAS),
    .STOP_CYC(T_STOP), .CLK_HALF(T_HALF)) lcdh_seq_inst (.clk_i(clk_i), .rst_i(rst_i),
    .link_clk_i(link_clk_i),
    .power_up_i(cmd[0]), .power_down_i(cmd[1]), .save_enter_i(cmd[2]), .save_exit_i(cmd[3]),
    .clock_source_select_i(ext), .booster_enable_i(boost), .contrast_path_select_i(ctc),
    .method_word_i(w[0]), .contrast_word_i(w[1]), .ram_word_i(w[2]), .line_word_i(w[3]),
    .onoff_word_i(w[4]), .busy_o(busy), .display_on_o(don), .saving_o(sav), .state_o(st),
    .active_low_reset_pin_n_o(rpin), .clock_input_pin_o(cpin), .ser_en_o(sen),
    .ser_clk_o(sclk), .ser_dat_o(sdat));
  lcdh_dev_model lcdh_dev_model_inst (.active_low_reset_pin_n_i(rpin), .ser_en_i(sen),
    .ser_clk_i(sclk), .ser_dat_i(sdat), .word_o(mword), .word_cnt_o(mcnt), .drv_off_o(doff));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen_v, exp_v);
    comparisons++;
    if (seen_v !== exp_v) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp_v, seen_v);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  function automatic logic [31:0] f_meth(logic [31:0] v, logic e, logic b, logic [1:0] c);
    return {v[31:4], c, b, e};
  endfunction
  function automatic logic [31:0] f_onoff(logic [31:0] v, logic [2:0] m);
    return {v[31:3], m};
  endfunction
  task automatic pulse(input int i);
    @(posedge clk_i);
    cmd[i] <= 1'b1;
    @(posedge clk_i);
    cmd[i] <= 1'b0;
  endtask
  task automatic get_word(input string what, input logic [31:0] exp_v);
    int n;
    n = 0;
    while (mcnt == got && n < 20000) begin
      @(posedge clk_i);
      n++;
    end
    got++;
    check("word count", 32'(mcnt), 32'(got));
    check(what, mword, exp_v);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    @(posedge clk_i);
  endtask
  task automatic bring_up;
    pulse(0);
    get_word("method", f_meth(w[0], ext, boost, ctc));
    get_word("contrast", w[1]);
    get_word("ram", w[2]);
    get_word("line", w[3]);
    get_word("on", f_onoff(w[4], 3'h0));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(12));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_i);
      ext   <= (k > 1) ? 1'($urandom) : (k == 0);
      boost <= (k > 1) ? 1'($urandom) : (k == 0);
      ctc   <= 2'($urandom);
      foreach (w[j]) w[j] <= $urandom;
      bring_up();
      wait_idle();
      check("display on", {31'h0, don}, 32'h1);
      check("outputs live", {31'h0, doff}, 32'h0);
      // Commands outside their state must send nothing
      pulse(0);
      pulse(3);
      repeat (50) @(posedge clk_i);
      check("refused", 32'(mcnt), 32'(got));
      pulse(2);
      get_word("save", f_onoff(w[4], 3'h7));
      wait_idle();
      check("saving", {31'h0, sav}, 32'h1);
      pulse(3);
      get_word("wake", f_onoff(w[4], 3'h3));
      get_word("resume", f_onoff(w[4], 3'h0));
      wait_idle();
      check("resumed", {31'h0, don}, 32'h1);
      pulse(1);
      get_word("standby", f_onoff(w[4], 3'h4));
      wait_idle();
      check("reset pin", {31'h0, rpin}, 32'h0);
      check("state", {27'h0, st}, 32'(ST_OFF));
      check("outputs off", {31'h0, doff}, 32'h1);
      $display("test %0d done", k);
    end
    // Reset in mid-word: the partial frame is dropped and start-up repeats
    pulse(0);
    while (sen !== 1'b1) @(posedge clk_i);
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("reset pin low", {31'h0, rpin}, 32'h0);
    check("idle", {31'h0, busy}, 32'h0);
    check("reset outputs off", {31'h0, doff}, 32'h1);
    bring_up();
    $display("test reset done");
    final_report();
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    error_cnt++;
    final_report();
  end
endmodule // tb_lcdh_seq
